/* File: logic/cpc_charge_param_regs.sv */
// Purpose: Three charge parameter configuration registers and their watchdog
// Assumes: Register port is the device's internal access path behind its serial interface
// Notes: Effective settings are the stored codes after clamping and zone limits
// Operation
// - Reset values are 0x12 at 0x03, 0x40 at 0x04 and 0x9E at 0x05.
// - Pre-charge current code sits in bits 7:4 as 20 mA plus 20 mA per step, default 0001.
// - Pre-charge codes above 1100 act as 1100.
// - Termination code sits in bits 3:0, default 0010, clamped above 1100.
// - Charge voltage codes 00000 to 01000 map to a fixed table, default 01000.
// - Charge voltage codes 01001 and up give 4.300 V plus 10 mV per step.
// - Top-off field bits 2:1 select off, 15, 30 or 45 minutes.
// - Bit 0 of the voltage register selects a 120 mV or 210 mV recharge threshold.
// - Bit 7 of control one enables termination; when clear charging never terminates.
// - Watchdog field bits 5:4 select off, 40 s, 80 s or 160 s.
// - Bit 3 gates both safety timers; pre-charge timer is 2 hours.
// - Bit 2 selects 20 hours when clear and 10 hours when set.
// - Bit 1 selects a 90 C or 110 C thermal threshold.
// - In the warm zone bit 0 clear caps the charge voltage at 4.1 V.
// - Writing 1 to the watchdog restart restarts the timer and the bit clears itself.
// - With timer stretch enabled the safety timer runs at half speed in regulation or zones.
`include "cpc_defines.svh"

module cpc_charge_param_regs
  import cpc_pkg::*;
#(
  parameter int TICK_CYCLES = `CPC_TICK_CYCLES,
  parameter int WD_BASE_MS = `CPC_WD_BASE_S * `CPC_MS_PER_S
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regAddrValid,
  // Control from neighbouring logic
  input wire logic registerReset,
  input wire logic watchdogRestart,
  input wire logic timerStretchEnable,
  input wire logic preChargePhase,
  input wire logic stretchCondition,
  input wire logic warmZone,
  // Effective settings and state
  output cpc_settings_t settings,
  output logic watchdogExpired,
  output logic watchdogRestartBit
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (TICK_CYCLES < 1) begin : g_badTick
    $error("cpc_charge_param_regs: tick count must be positive");
  end

  if (WD_BASE_MS < 1) begin : g_badWdBase
    $error("cpc_charge_param_regs: watchdog base must be positive");
  end

  // Longest period is four times the base and must fit the millisecond counter
  if (WD_BASE_MS * 4 >= (1 << 18)) begin : g_badWdRange
    $error("cpc_charge_param_regs: watchdog period exceeds counter");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  cpc_prechg_term_t prechgTerm_ff, nxt_prechgTerm;
  cpc_volt_limit_t voltLimit_ff, nxt_voltLimit;
  cpc_ctrl_one_t ctrlOne_ff, nxt_ctrlOne;
  logic [7:0] regRdData_ff, nxt_regRdData;
  logic wdExpire;

  // Register reset and watchdog expiry beat a host write in the same cycle
  always_comb begin
    nxt_prechgTerm = prechgTerm_ff;
    nxt_voltLimit = voltLimit_ff;
    nxt_ctrlOne = ctrlOne_ff;

    if (registerReset || wdExpire) begin
      nxt_prechgTerm = `CPC_RST_PRECHG_TERM;
      nxt_voltLimit = `CPC_RST_VOLT_LIMIT;
      nxt_ctrlOne = `CPC_RST_CTRL_ONE;
    end else if (regWrite) begin
      // Writes to unmapped offsets are ignored
      unique case (regAddr)
        `CPC_ADDR_PRECHG_TERM: nxt_prechgTerm = regWrData;
        `CPC_ADDR_VOLT_LIMIT: nxt_voltLimit = regWrData;
        `CPC_ADDR_CTRL_ONE: nxt_ctrlOne = regWrData;
        default: ;
      endcase
    end
  end

  // Read data is registered and holds until the next read
  always_comb begin
    nxt_regRdData = regRdData_ff;

    if (regRead) begin
      unique case (regAddr)
        `CPC_ADDR_PRECHG_TERM: nxt_regRdData = prechgTerm_ff;
        `CPC_ADDR_VOLT_LIMIT: nxt_regRdData = voltLimit_ff;
        `CPC_ADDR_CTRL_ONE: nxt_regRdData = ctrlOne_ff;
        default: nxt_regRdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prechgTerm_ff <= `CPC_RST_PRECHG_TERM;
      voltLimit_ff <= `CPC_RST_VOLT_LIMIT;
      ctrlOne_ff <= `CPC_RST_CTRL_ONE;
      regRdData_ff <= 8'h00;
    end else begin
      prechgTerm_ff <= nxt_prechgTerm;
      voltLimit_ff <= nxt_voltLimit;
      ctrlOne_ff <= nxt_ctrlOne;
      regRdData_ff <= nxt_regRdData;
    end
  end

  assign regRdData = regRdData_ff;
  assign regAddrValid = (regAddr == `CPC_ADDR_PRECHG_TERM) || (regAddr == `CPC_ADDR_VOLT_LIMIT)
      || (regAddr == `CPC_ADDR_CTRL_ONE);

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: millisecond tick and period counter

  logic [$clog2(TICK_CYCLES+1)-1:0] tickCnt_ff, nxt_tickCnt;
  logic [17:0] wdMs_ff, nxt_wdMs;
  logic restartPend_ff, nxt_restartPend;
  logic expired_ff, nxt_expired;
  logic msTick;
  logic [17:0] wdLimit;

  assign msTick = (tickCnt_ff == ($bits(tickCnt_ff))'(TICK_CYCLES - 1));

  always_comb begin
    unique case (ctrlOne_ff.watchdogPeriod)
      2'h1: wdLimit = 18'(WD_BASE_MS);
      2'h2: wdLimit = 18'(WD_BASE_MS * 2);
      2'h3: wdLimit = 18'(WD_BASE_MS * 4);
      default: wdLimit = 18'h00000;
    endcase
  end

  // Expiry on the tick that completes the period; a pending restart wins
  assign wdExpire = (ctrlOne_ff.watchdogPeriod != 2'h0) && msTick && !restartPend_ff
      && !watchdogRestart && (wdMs_ff >= wdLimit - 18'h00001);

  always_comb begin
    // Free-running prescaler for the millisecond tick
    if (msTick) begin
      nxt_tickCnt = '0;
    end else begin
      nxt_tickCnt = tickCnt_ff + 1'b1;
    end

    // Restart bit reads back set for one cycle, then clears itself
    nxt_restartPend = watchdogRestart;

    // One-cycle expiry pulse
    nxt_expired = wdExpire;

    // Elapsed time restarts on host restart, when disabled, on expiry or register reset
    nxt_wdMs = wdMs_ff;
    if (restartPend_ff) begin
      nxt_wdMs = 18'h00000;
    end else if (ctrlOne_ff.watchdogPeriod == 2'h0) begin
      nxt_wdMs = 18'h00000;
    end else if (wdExpire || registerReset) begin
      nxt_wdMs = 18'h00000;
    end else if (msTick) begin
      nxt_wdMs = wdMs_ff + 18'h00001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_ff <= '0;
      wdMs_ff <= 18'h00000;
      restartPend_ff <= 1'b0;
      expired_ff <= 1'b0;
    end else begin
      tickCnt_ff <= nxt_tickCnt;
      wdMs_ff <= nxt_wdMs;
      restartPend_ff <= nxt_restartPend;
      expired_ff <= nxt_expired;
    end
  end

  assign watchdogExpired = expired_ff;
  assign watchdogRestartBit = restartPend_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Effective settings

  logic [3:0] rawCurrent [2];
  logic [3:0] clampedCurrent [2];

  assign rawCurrent[0] = prechgTerm_ff.prechargeCurrentCode;
  assign rawCurrent[1] = prechgTerm_ff.terminationCurrentCode;

  // Both current fields share one clamp: codes above the top step act as the top step
  for (genvar ch = 0; ch < 2; ch++) begin : g_clamp
    assign clampedCurrent[ch] = (rawCurrent[ch] > `CPC_CURRENT_MAX_CODE)
        ? `CPC_CURRENT_MAX_CODE : rawCurrent[ch];
  end

  cpc_settings_t settings_ff, nxt_settings;

  always_comb begin
    nxt_settings = '0;

    // Current codes
    nxt_settings.prechargeCurrent = clampedCurrent[0];
    nxt_settings.terminationCurrent = clampedCurrent[1];

    // Charge voltage code, capped in the warm zone unless the full target is chosen
    nxt_settings.chargeVoltage = voltLimit_ff.chargeVoltageCode;
    if (warmZone && !ctrlOne_ff.warmZoneVoltageSel) begin
      if (voltLimit_ff.chargeVoltageCode > `CPC_VOLT_WARM_CODE) begin
        nxt_settings.chargeVoltage = `CPC_VOLT_WARM_CODE;
      end
    end

    // Top-off and recharge selections pass through
    nxt_settings.topoffDuration = voltLimit_ff.topoffDurationSel;
    nxt_settings.rechargeThresholdHigh = voltLimit_ff.rechargeThresholdSel;

    // Termination
    nxt_settings.termEnable = ctrlOne_ff.termEnable;

    // Safety timer: zero hours means no limit
    nxt_settings.safetyTimerEnable = ctrlOne_ff.safetyTimerEnable;
    if (!ctrlOne_ff.safetyTimerEnable) begin
      nxt_settings.safetyHours = 5'h00;
    end else if (preChargePhase) begin
      nxt_settings.safetyHours = 5'(`CPC_PRECHG_HOURS);
    end else if (ctrlOne_ff.fastChargeTimerSel) begin
      nxt_settings.safetyHours = 5'(`CPC_FAST_SHORT_HOURS);
    end else begin
      nxt_settings.safetyHours = 5'(`CPC_FAST_LONG_HOURS);
    end

    // Thermal regulation threshold
    nxt_settings.thermalHigh = ctrlOne_ff.thermalRegulationSel;

    // Half speed only when stretching is enabled and a slowing cause is present
    nxt_settings.timerHalfSpeed = timerStretchEnable && stretchCondition;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      settings_ff <= '0;
    end else begin
      settings_ff <= nxt_settings;
    end
  end

  assign settings = settings_ff;

endmodule : cpc_charge_param_regs

/* File: logic/cpc_defines.svh */
// Purpose: Offsets, reset values, limit codes and timing counts of the charge config bank
// Assumes: 20 MHz system clock
// Notes: Times are kept in their own unit; cycle counts derive from them
`ifndef CPC_DEFINES_SVH
`define CPC_DEFINES_SVH

`define CPC_ADDR_PRECHG_TERM 8'h03
`define CPC_ADDR_VOLT_LIMIT 8'h04
`define CPC_ADDR_CTRL_ONE 8'h05

`define CPC_RST_PRECHG_TERM 8'h12
`define CPC_RST_VOLT_LIMIT 8'h40
`define CPC_RST_CTRL_ONE 8'h9E

`define CPC_CURRENT_MAX_CODE 4'hC
`define CPC_VOLT_WARM_CODE 5'h06

`define CPC_CLK_HZ 20000000
`define CPC_MS_PER_S 1000
`define CPC_TICK_MS 1
`define CPC_TICK_CYCLES (`CPC_CLK_HZ / 1000 * `CPC_TICK_MS)
`define CPC_WD_BASE_S 40
`define CPC_TOPOFF_BASE_MIN 15
`define CPC_PRECHG_HOURS 2
`define CPC_FAST_LONG_HOURS 20
`define CPC_FAST_SHORT_HOURS 10
`define CPC_THERM_LOW_C 90
`define CPC_THERM_HIGH_C 110
`define CPC_RECHG_LOW_MV 120
`define CPC_RECHG_HIGH_MV 210

`endif

/* File: logic/cpc_pkg.sv */
// Purpose: Types of the charge config bank
// Assumes: Used with cpc_defines.svh
// Notes: Field layouts as packed structs, msb first
package cpc_pkg;
  typedef struct packed {
    logic [3:0] prechargeCurrentCode;
    logic [3:0] terminationCurrentCode;
  } cpc_prechg_term_t;

  typedef struct packed {
    logic [4:0] chargeVoltageCode;
    logic [1:0] topoffDurationSel;
    logic rechargeThresholdSel;
  } cpc_volt_limit_t;

  typedef struct packed {
    logic termEnable;
    logic reservedBit;
    logic [1:0] watchdogPeriod;
    logic safetyTimerEnable;
    logic fastChargeTimerSel;
    logic thermalRegulationSel;
    logic warmZoneVoltageSel;
  } cpc_ctrl_one_t;

  typedef struct packed {
    logic [3:0] prechargeCurrent;
    logic [3:0] terminationCurrent;
    logic [4:0] chargeVoltage;
    logic [1:0] topoffDuration;
    logic rechargeThresholdHigh;
    logic termEnable;
    logic safetyTimerEnable;
    logic [4:0] safetyHours;
    logic thermalHigh;
    logic timerHalfSpeed;
  } cpc_settings_t;
endpackage : cpc_pkg

/* File: sim/cpc_host_model.sv */
// Purpose: Host side of the register port
// Assumes: Requests change just after a rising edge
// Notes: Released data shows the inverse value
module cpc_host_model (
  // Clock
  input wire logic clk_sys,
  // Requests and answer
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic watchdogRestart,
  input wire logic [7:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {regWrite, regRead, watchdogRestart, regAddr, regWrData} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {regWrite, regAddr, regWrData} <= {1'b1, a, d};
    @(posedge clk_sys);
    {regWrite, regWrData} <= {1'b0, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    {regRead, regAddr} <= {1'b1, a};
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(posedge clk_sys);
    d = regRdData;
  endtask : rd
  task automatic restart();
    @(posedge clk_sys);
    watchdogRestart <= 1'b1;
    @(posedge clk_sys);
    watchdogRestart <= 1'b0;
  endtask : restart
endmodule : cpc_host_model

/* File: sim/cpc_param_properties.sv */
// Purpose: Port checks of the charge config bank
// Assumes: One clock, async low reset
// Notes: Bound from tb
module cpc_param_properties
  import cpc_pkg::*;
(
  // Clock, reset, requests
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic registerReset,
  input wire logic watchdogRestart,
  input wire logic timerStretchEnable,
  input wire logic stretchCondition,
  // Watched outputs
  input wire cpc_settings_t settings,
  input wire logic watchdogExpired,
  input wire logic watchdogRestartBit
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  property p_clamp; settings.prechargeCurrent <= 4'hC && settings.terminationCurrent <= 4'hC;
  endproperty
  a_clamp: assert property (p_clamp) else $error("current code not clamped");
  property p_rb_set; watchdogRestart |=> watchdogRestartBit; endproperty
  a_rb_set: assert property (p_rb_set) else $error("restart bit not set");
  property p_rb_clr; watchdogRestartBit && !watchdogRestart |=> !watchdogRestartBit; endproperty
  a_rb_clr: assert property (p_rb_clr) else $error("restart bit stuck");
  property p_reg_rst; registerReset |-> ##2 settings.termEnable && settings.thermalHigh
    && settings.prechargeCurrent == 4'h1; endproperty
  a_reg_rst: assert property (p_reg_rst) else $error("no defaults after reset");
  property p_wd_exp; watchdogExpired |=> settings.safetyTimerEnable
    && settings.terminationCurrent == 4'h2; endproperty
  a_wd_exp: assert property (p_wd_exp) else $error("no defaults after expiry");
  property p_wr_ctl; (regWrite && regAddr == 8'h05 && !registerReset) ##1 !watchdogExpired
    |=> settings.termEnable == $past(regWrData[7], 2)
    && settings.thermalHigh == $past(regWrData[1], 2); endproperty
  a_wr_ctl: assert property (p_wr_ctl) else $error("control write lost");
  property p_hours; settings.safetyHours inside {5'h00, 5'h02, 5'h0A, 5'h14}
    && (settings.safetyTimerEnable || settings.safetyHours == 5'h00); endproperty
  a_hours: assert property (p_hours) else $error("bad safety hours");
  property p_half; settings.timerHalfSpeed |-> $past(timerStretchEnable)
    && $past(stretchCondition); endproperty
  a_half: assert property (p_half) else $error("half speed without cause");
endmodule : cpc_param_properties

/* File: sim/tb.sv */
// Purpose: Self-checking bench of the charge config bank
// Assumes: Shortened tick and watchdog base
// Notes: Random accesses from a fixed seed
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cpc_pkg::*;
  localparam int TK = 4;
  localparam int WB = 5;
  localparam logic [7:0] DV [3] = '{8'h12, 8'h40, 8'h9E};
  localparam logic [7:0] CV [3] = '{8'hFF, 8'hF9, 8'h1E};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic regWrite, regRead, watchdogRestart, regAddrValid, watchdogExpired, watchdogRestartBit;
  logic registerReset, timerStretchEnable, preChargePhase, stretchCondition, warmZone;
  logic [7:0] regAddr, regWrData, regRdData, v, a, d;
  logic [7:0] regs [3];
  cpc_settings_t settings;
  int errTotal = 0;
  int testsRun = 0;
  int seed = 81182;
  int n;
  always #25 clk_sys = ~clk_sys;
  cpc_charge_param_regs #(.TICK_CYCLES(TK), .WD_BASE_MS(WB)) u_dut (.clk_sys(clk_sys),
    .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regAddrValid(regAddrValid),
    .registerReset(registerReset), .watchdogRestart(watchdogRestart),
    .timerStretchEnable(timerStretchEnable), .preChargePhase(preChargePhase),
    .stretchCondition(stretchCondition), .warmZone(warmZone), .settings(settings),
    .watchdogExpired(watchdogExpired), .watchdogRestartBit(watchdogRestartBit));
  cpc_host_model u_host (.clk_sys(clk_sys), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .watchdogRestart(watchdogRestart),
    .regRdData(regRdData));
  function automatic cpc_settings_t exp_set();
    cpc_settings_t s;
    s.prechargeCurrent = regs[0][7:4] > 4'hC ? 4'hC : regs[0][7:4];
    s.terminationCurrent = regs[0][3:0] > 4'hC ? 4'hC : regs[0][3:0];
    s.chargeVoltage = (warmZone && !regs[2][0] && regs[1][7:3] > 5'h06) ? 5'h06 : regs[1][7:3];
    {s.topoffDuration, s.rechargeThresholdHigh} = regs[1][2:0];
    {s.termEnable, s.safetyTimerEnable, s.thermalHigh} = {regs[2][7], regs[2][3], regs[2][1]};
    s.safetyHours = !regs[2][3] ? 5'h00 : preChargePhase ? 5'h02 : regs[2][2] ? 5'h0A : 5'h14;
    s.timerHalfSpeed = timerStretchEnable && stretchCondition;
    return s;
  endfunction : exp_set
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  task automatic dflt(input string s);
    regs = DV;
    for (int k = 0; k < 3; k++) begin
      u_host.rd(8'h03 + 8'(k), v);
      chk(32'(v), 32'(DV[k]));
    end
    chk(32'(settings), 32'(exp_set()));
    $display("%s done", s);
  endtask : dflt
  initial begin
    {registerReset, timerStretchEnable, preChargePhase, stretchCondition, warmZone} = '0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    dflt("reset");
    for (int i = 0; i < 40; i++) begin
      a = (i < 3) ? 8'h03 + 8'(i) : 8'h03 + 8'($unsigned($random(seed)) % 4);
      d = (i < 3) ? CV[i] : 8'($random(seed));
      {warmZone, preChargePhase, timerStretchEnable, stretchCondition} <=
        (i < 3) ? 4'h8 : 4'($random(seed));
      u_host.restart();
      u_host.wr(a, d);
      if (a != 8'h06) regs[a - 8'h03] = d;
      repeat (3) @(posedge clk_sys);
      chk(32'(settings), 32'(exp_set()));
      u_host.rd(a, v);
      chk(32'(v), 32'(a == 8'h06 ? 8'h00 : regs[a - 8'h03]));
      chk(32'(regAddrValid), 32'(a != 8'h06));
    end
    $display("random done");
    for (int p = 0; p < 4; p++) begin
      u_host.wr(8'h05, 8'h40 | 8'(p << 4));
      u_host.restart();
      n = 0;
      while (watchdogExpired !== 1'b1 && n < 300) begin
        @(negedge clk_sys);
        n++;
      end
      chk(32'(p == 0 ? n == 300 : n > ((TK * WB) << (p - 1)) - 8
        && n < ((TK * WB) << (p - 1)) + 8), 32'h1);
      if (p != 0 && n == 300) conclude();
      u_host.rd(8'h05, v);
      chk(32'(v), 32'(p == 0 ? 8'h40 : 8'h9E));
    end
    $display("watchdog done");
    u_host.wr(8'h03, 8'h55);
    @(posedge clk_sys);
    registerReset <= 1'b1;
    @(posedge clk_sys);
    registerReset <= 1'b0;
    dflt("register reset");
    conclude();
  end
endmodule : tb
bind cpc_charge_param_regs cpc_param_properties u_props (.clk_sys(clk_sys), .rst_n(rst_n),
  .regWrite(regWrite), .regAddr(regAddr), .regWrData(regWrData),
  .registerReset(registerReset), .watchdogRestart(watchdogRestart),
  .timerStretchEnable(timerStretchEnable), .stretchCondition(stretchCondition),
  .settings(settings), .watchdogExpired(watchdogExpired),
  .watchdogRestartBit(watchdogRestartBit));
